//--- common/aff_pkg.sv
package aff_pkg;

    // Bus geometry
    localparam int AFF_ADDR_W = 8;
    localparam int AFF_DATA_W = 32;
    localparam int AFF_STRB_W = 4;

    // Register byte offsets
    localparam logic [7:0] AFF_OFS_FLAGS = 8'h00;
    localparam logic [7:0] AFF_OFS_IRQ_STAT = 8'h04;
    localparam logic [7:0] AFF_OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] AFF_OFS_RAW = 8'h0c;

    // Flag word layout
    localparam int AFF_FLAG_W = 12;
    localparam int AFF_OVR_N = 4;
    localparam int AFF_BIT_OVR_LO = 8;
    localparam int AFF_BIT_PWRUP = 7;
    localparam int AFF_BIT_UVLOCK = 6;
    localparam int AFF_BIT_POS_HI = 5;
    localparam int AFF_BIT_POS_LO = 4;
    localparam int AFF_BIT_NEG_HI = 3;
    localparam int AFF_BIT_NEG_LO = 2;
    localparam int AFF_BIT_REF_L1 = 1;
    localparam int AFF_BIT_REF_L0 = 0;

    // Reset values
    localparam logic [11:0] AFF_FLAGS_RST = 12'h0c0;
    localparam logic [11:0] AFF_SYNC_RST = 12'h040;
    localparam logic [11:0] AFF_IRQ_STAT_RST = 12'h000;
    localparam logic [11:0] AFF_IRQ_MASK_RST = 12'h000;
    localparam logic [31:0] AFF_RDATA_RST = 32'h0000_0000;

    // Synchroniser depth
    localparam int AFF_SYNC_STAGES = 2;

endpackage

//--- common/aff_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

// Raw comparator levels in, clean register-domain levels out
interface aff_sync_if #(
    parameter int WIDTH = 12
);
    logic [WIDTH-1:0] async_lvl;
    logic [WIDTH-1:0] sync_lvl;

    modport owner (
        output async_lvl,
        input sync_lvl
    );

    modport syncer (
        input async_lvl,
        output sync_lvl
    );
endinterface

`default_nettype wire

//--- design/aff_sync.sv
`timescale 1ns/1ps
`default_nettype none

module aff_sync
    import aff_pkg::*;
#(
    parameter int WIDTH = AFF_FLAG_W,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Levels
    aff_sync_if.syncer sif
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] clean_r;
    logic [WIDTH-1:0] clean_nxt;

    // First stage feeds only the second stage
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_comb begin
                meta_nxt[gi] = sif.async_lvl[gi];
                clean_nxt[gi] = meta_r[gi];
            end
        end
    endgenerate

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= RST_VAL;
            clean_r <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            clean_r <= clean_nxt;
        end
    end

    assign sif.sync_lvl = clean_r;

endmodule // aff_sync

`default_nettype wire

//--- design/aff_flags.sv
`timescale 1ns/1ps
`default_nettype none

module aff_flags
    import aff_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // APB slave
    input wire logic [AFF_ADDR_W-1:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [AFF_DATA_W-1:0] i_pwdata,
    input wire logic [AFF_STRB_W-1:0] i_pstrb,
    output logic [AFF_DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Analog monitor comparators, asynchronous levels
    input wire logic [AFF_OVR_N-1:0] i_path_overrange,
    input wire logic i_powerup_event,
    input wire logic i_undervoltage_lockout,
    input wire logic i_amp_pos_out_high_rail,
    input wire logic i_amp_pos_out_low_rail,
    input wire logic i_amp_neg_out_high_rail,
    input wire logic i_amp_neg_out_low_rail,
    input wire logic i_reference_low_level1,
    input wire logic i_reference_low_level0,
    // Interrupt
    output logic o_irq
);

    typedef enum logic [2:0] {
        AFF_SEL_NONE,
        AFF_SEL_FLAGS,
        AFF_SEL_STAT,
        AFF_SEL_MASK,
        AFF_SEL_RAW
    } aff_sel_t;

    aff_sync_if #(.WIDTH(AFF_FLAG_W)) sif ();

    // Register state
    logic [AFF_FLAG_W-1:0] flags_r;
    logic [AFF_FLAG_W-1:0] flags_nxt;
    logic [AFF_FLAG_W-1:0] irq_stat_r;
    logic [AFF_FLAG_W-1:0] irq_stat_nxt;
    logic [AFF_FLAG_W-1:0] irq_mask_r;
    logic [AFF_FLAG_W-1:0] irq_mask_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [AFF_DATA_W-1:0] prdata_r;
    logic [AFF_DATA_W-1:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;

    // Bus decode
    localparam int LANE_W = AFF_DATA_W / AFF_STRB_W;
    aff_sel_t sel;
    logic access;
    logic commit;
    logic wr_commit;
    logic [AFF_DATA_W-1:0] lane_mask;
    logic [AFF_FLAG_W-1:0] wr_bits;
    logic [AFF_FLAG_W-1:0] wr_en;
    logic [AFF_FLAG_W-1:0] rise;
    logic [AFF_DATA_W-1:0] rd_word;

    // Per-register write strobes
    logic [AFF_FLAG_W-1:0] flags_wr;
    logic [AFF_FLAG_W-1:0] stat_wr;
    logic [AFF_FLAG_W-1:0] mask_wr;
    logic [AFF_FLAG_W-1:0] stat_clr;
    logic pwrup_clr;

    // Interrupt and response helpers
    logic [AFF_FLAG_W-1:0] irq_pend;
    logic resp_now;
    logic resp_err;
    logic [AFF_DATA_W-1:0] resp_data;

    genvar gi;

    // Comparator levels in flag order
    always_comb begin
        sif.async_lvl = '0;
        sif.async_lvl[AFF_BIT_OVR_LO +: AFF_OVR_N] = i_path_overrange;
        sif.async_lvl[AFF_BIT_PWRUP] = i_powerup_event;
        sif.async_lvl[AFF_BIT_UVLOCK] = i_undervoltage_lockout;
        sif.async_lvl[AFF_BIT_POS_HI] = i_amp_pos_out_high_rail;
        sif.async_lvl[AFF_BIT_POS_LO] = i_amp_pos_out_low_rail;
        sif.async_lvl[AFF_BIT_NEG_HI] = i_amp_neg_out_high_rail;
        sif.async_lvl[AFF_BIT_NEG_LO] = i_amp_neg_out_low_rail;
        sif.async_lvl[AFF_BIT_REF_L1] = i_reference_low_level1;
        sif.async_lvl[AFF_BIT_REF_L0] = i_reference_low_level0;
    end

    // Lockout stage resets high so the flag does not dip after reset
    aff_sync #(
        .WIDTH(AFF_FLAG_W),
        .RST_VAL(AFF_SYNC_RST)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .sif(sif.syncer)
    );

    // Transfer phase qualifiers
    always_comb begin
        access = i_psel & i_penable;
        commit = access & pready_r;
        wr_commit = commit & i_pwrite;
    end

    // Address decode; anything off the map answers with an error
    always_comb begin
        case (i_paddr)
            AFF_OFS_FLAGS: sel = AFF_SEL_FLAGS;
            AFF_OFS_IRQ_STAT: sel = AFF_SEL_STAT;
            AFF_OFS_IRQ_MASK: sel = AFF_SEL_MASK;
            AFF_OFS_RAW: sel = AFF_SEL_RAW;
            default: sel = AFF_SEL_NONE;
        endcase
    end

    // Byte lanes; only the two low lanes reach a flag bit
    always_comb begin
        lane_mask = '0;
        for (int b = 0; b < AFF_STRB_W; b++) begin
            lane_mask[b*LANE_W +: LANE_W] = {LANE_W{i_pstrb[b]}};
        end
        wr_bits = i_pwdata[AFF_FLAG_W-1:0];
        wr_en = wr_commit ? lane_mask[AFF_FLAG_W-1:0] : '0;
    end

    // Strobes only on the completing edge, so a stalled access never writes twice
    always_comb begin
        flags_wr = (sel == AFF_SEL_FLAGS) ? wr_en : '0;
        stat_wr = (sel == AFF_SEL_STAT) ? wr_en : '0;
        mask_wr = (sel == AFF_SEL_MASK) ? wr_en : '0;
        stat_clr = stat_wr & wr_bits;
    end

    // Power-up bit: a zero written through lane 0 clears it
    always_comb begin
        pwrup_clr = flags_wr[AFF_BIT_PWRUP] & ~wr_bits[AFF_BIT_PWRUP];
    end

    // Live bits copy the clean level; only the power-up bit is sticky
    generate
        for (gi = 0; gi < AFF_FLAG_W; gi++) begin : g_flag
            if (gi == AFF_BIT_PWRUP) begin : g_sticky
                always_comb begin
                    flags_nxt[gi] = flags_r[gi];
                    if (pwrup_clr) begin
                        flags_nxt[gi] = 1'b0;
                    end
                    // A new event wins over a clear in the same cycle
                    if (sif.sync_lvl[gi]) begin
                        flags_nxt[gi] = 1'b1;
                    end
                end
            end else begin : g_live
                always_comb begin
                    flags_nxt[gi] = sif.sync_lvl[gi];
                end
            end
        end
    endgenerate

    // Status bits catch rising flags; a set beats a clear in the same cycle
    generate
        for (gi = 0; gi < AFF_FLAG_W; gi++) begin : g_irq
            always_comb begin
                rise[gi] = flags_nxt[gi] & ~flags_r[gi];
                irq_stat_nxt[gi] = (irq_stat_r[gi] & ~stat_clr[gi]) | rise[gi];
                irq_mask_nxt[gi] = mask_wr[gi] ? wr_bits[gi] : irq_mask_r[gi];
                irq_pend[gi] = irq_stat_nxt[gi] & irq_mask_nxt[gi];
            end
        end
    endgenerate

    // Taken from next state so the pin does not lag the status by a cycle
    always_comb begin
        irq_nxt = |irq_pend;
    end

    // Read mux; bits above the flag word read 0
    always_comb begin
        rd_word = '0;
        case (sel)
            AFF_SEL_FLAGS: rd_word[AFF_FLAG_W-1:0] = flags_r;
            AFF_SEL_STAT: rd_word[AFF_FLAG_W-1:0] = irq_stat_r;
            AFF_SEL_MASK: rd_word[AFF_FLAG_W-1:0] = irq_mask_r;
            AFF_SEL_RAW: rd_word[AFF_FLAG_W-1:0] = sif.sync_lvl;
            default: rd_word = '0;
        endcase
    end

    // One wait state: the answer is formed in the first access cycle
    always_comb begin
        resp_now = access & ~pready_r;
        resp_err = (sel == AFF_SEL_NONE);
        resp_data = i_pwrite ? AFF_RDATA_RST : rd_word;
    end

    // Answer stands one cycle, then the bus returns to idle zeros
    always_comb begin
        pready_nxt = resp_now;
        prdata_nxt = AFF_RDATA_RST;
        pslverr_nxt = 1'b0;
        if (resp_now) begin
            prdata_nxt = resp_err ? AFF_RDATA_RST : resp_data;
            pslverr_nxt = resp_err;
        end
    end

    // Flag group
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            flags_r <= AFF_FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Interrupt group
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_stat_r <= AFF_IRQ_STAT_RST;
            irq_mask_r <= AFF_IRQ_MASK_RST;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Bus response group
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prdata_r <= AFF_RDATA_RST;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_irq = irq_r;

endmodule // aff_flags

`default_nettype wire

//--- testbench/aff_flags_checker.sv
`timescale 1ns/1ps
`default_nettype none

module aff_flags_checker
    import aff_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [AFF_ADDR_W-1:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [AFF_DATA_W-1:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [AFF_OVR_N-1:0] i_path_overrange,
    input wire logic i_undervoltage_lockout,
    input wire logic i_reference_low_level0
);
    default clocking dcb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    logic rd_flags;
    logic [5:0] live;
    assign rd_flags = o_pready && !i_pwrite && i_paddr == AFF_OFS_FLAGS;
    assign live = {i_path_overrange, i_undervoltage_lockout, i_reference_low_level0};
    // Long enough to pass both sync flops and the flag register
    sequence s_quiet;
        $stable(live)[*5];
    endsequence
    a_wait_state: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready held too long");
    a_err_map: assert property (o_pready |->
        o_pslverr == (i_paddr > AFF_OFS_RAW || i_paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside transfer");
    a_err_data: assert property (o_pslverr |-> o_prdata == 32'h0)
        else $error("read data on error");
    a_err_pulse: assert property (o_pslverr |-> o_pready)
        else $error("pslverr outside transfer");
    a_write_zero: assert property (o_pready && i_pwrite |-> o_prdata == 32'h0)
        else $error("read data on write");
    a_ovr_live: assert property (s_quiet ##0 rd_flags |-> o_prdata[11:8] == live[5:2])
        else $error("over-range bits wrong");
    a_lock_live: assert property (s_quiet ##0 rd_flags |-> o_prdata[6] == live[1])
        else $error("lockout bit wrong");
    a_ref0_live: assert property (s_quiet ##0 rd_flags |-> o_prdata[0] == live[0])
        else $error("reference level0 bit wrong");
endmodule // aff_flags_checker

bind aff_flags aff_flags_checker u_chk (.*);

`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import aff_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic i_powerup_event = 1'b0, i_undervoltage_lockout = 1'b1;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [3:0] i_pstrb = 4'hf;
    logic [3:0] i_path_overrange = 4'h0;
    logic [5:0] rails = 6'h00;
    wire logic i_amp_pos_out_high_rail = rails[5];
    wire logic i_amp_pos_out_low_rail = rails[4];
    wire logic i_amp_neg_out_high_rail = rails[3];
    wire logic i_amp_neg_out_low_rail = rails[2];
    wire logic i_reference_low_level1 = rails[1];
    wire logic i_reference_low_level0 = rails[0];
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_irq;
    logic [32:0] expq[$];
    int err_total = 0;
    int checks = 0;

    always #2 i_clk = ~i_clk;

    aff_flags uut (.*);

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp(input logic [32:0] e, input logic [32:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_irq(input logic e);
        checks++;
        if (o_irq !== e) begin
            err_total++;
            $display("ERROR %0t irq got %b expected %b", $time, o_irq, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // Expected read word: error bit, then flag word
    function automatic logic [32:0] fw(input logic p);
        return {21'h0, i_path_overrange, p, i_undervoltage_lockout, rails};
    endfunction

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        if (!w)
            expq.push_back(e);
        i_paddr <= a;
        i_pwrite <= w;
        i_pwdata <= d;
        i_psel <= 1'b1;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n == 20) begin
            err_total++;
            $display("ERROR %0t no pready", $time);
            report_and_stop();
        end
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask

    always @(posedge i_clk) begin
        if (o_pready === 1'b1 && !i_pwrite)
            cmp(expq.pop_front(), {o_pslverr, o_prdata});
    end

    initial begin
        void'($urandom(42151));
        cyc(8);
        i_rst <= 1'b0;
        cyc(1);
        apb(AFF_OFS_FLAGS, 1'b0, 32'h0, fw(1'b1));
        apb(AFF_OFS_IRQ_STAT, 1'b0, 32'h0, 33'h0);
        apb(AFF_OFS_IRQ_MASK, 1'b0, 32'h0, 33'h0);
        $display("reset test done");
        // Ones in read-only bits must not stick
        apb(AFF_OFS_FLAGS, 1'b1, 32'hf7f, 33'h0);
        apb(AFF_OFS_FLAGS, 1'b0, 32'h0, fw(1'b0));
        i_powerup_event <= 1'b1;
        cyc(2);
        i_powerup_event <= 1'b0;
        cyc(4);
        apb(AFF_OFS_FLAGS, 1'b0, 32'h0, fw(1'b1));
        // Lane 0 off: a zero in bit 7 must not clear it
        i_pstrb <= 4'he;
        apb(AFF_OFS_FLAGS, 1'b1, 32'h0, 33'h0);
        i_pstrb <= 4'hf;
        apb(AFF_OFS_FLAGS, 1'b0, 32'h0, fw(1'b1));
        apb(AFF_OFS_FLAGS, 1'b1, 32'h0, 33'h0);
        $display("power-up flag test done");
        for (int k = 0; k < 8; k++) begin
            {i_path_overrange, i_undervoltage_lockout, rails} <= 11'($urandom);
            cyc(4);
            apb(AFF_OFS_FLAGS, 1'b0, 32'h0, fw(1'b0));
        end
        $display("live flag test done");
        {i_path_overrange, i_undervoltage_lockout, rails} <= 11'h0;
        cyc(4);
        apb(AFF_OFS_IRQ_MASK, 1'b1, 32'hfff, 33'h0);
        apb(AFF_OFS_IRQ_STAT, 1'b1, 32'hfff, 33'h0);
        i_path_overrange <= 4'h8;
        cyc(6);
        cmp_irq(1'b1);
        // Raw view ignores writes and shows the clean levels
        apb(AFF_OFS_RAW, 1'b1, 32'hfff, 33'h0);
        apb(AFF_OFS_RAW, 1'b0, 32'h0, fw(1'b0));
        apb(AFF_OFS_IRQ_STAT, 1'b0, 32'h0, 33'h800);
        apb(AFF_OFS_IRQ_MASK, 1'b1, 32'h0, 33'h0);
        cyc(2);
        cmp_irq(1'b0);
        apb(AFF_OFS_IRQ_MASK, 1'b1, 32'h800, 33'h0);
        cyc(2);
        cmp_irq(1'b1);
        // Level still high, yet only a new rise may set status again
        apb(AFF_OFS_IRQ_STAT, 1'b1, 32'h800, 33'h0);
        cyc(2);
        cmp_irq(1'b0);
        $display("interrupt test done");
        // Reset mid-run: power-up bit back to 1, mask back to 0
        i_rst <= 1'b1;
        cyc(2);
        i_rst <= 1'b0;
        cyc(4);
        cmp_irq(1'b0);
        apb(AFF_OFS_FLAGS, 1'b0, 32'h0, fw(1'b1));
        apb(AFF_OFS_IRQ_STAT, 1'b0, 32'h0, 33'h800);
        apb(AFF_OFS_IRQ_MASK, 1'b0, 32'h0, 33'h0);
        $display("mid-run reset test done");
        apb(8'h10, 1'b0, 32'h0, 33'h1_0000_0000);
        $display("unmapped test done");
        cyc(2);
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
